/* hdl/gpio_irq_pkg.sv */
// Constants shared by the port and edge interrupt register logic.
// Assumes a 16-bit register word and a 4-bit register index supplied by
// the serial link framing logic, which lives outside this block.
package gpio_irq_pkg;

  // ****************************************************************
  // Register word and index
  // ****************************************************************
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned PIN_COUNT = 10;

  // Register indices on the link
  localparam logic [ADDR_W-1:0] ADDR_PIN_DATA = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_DIRECTION = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_RISE_ENABLE = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_FALL_ENABLE = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR_STATUS = 4'h4;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned BIT_DRIVE_LOW = 15;
  localparam int unsigned BIT_CONV_READY = 11;
  localparam int unsigned BIT_PLATE_XPOS = 12;
  localparam int unsigned BIT_PLATE_XNEG = 13;
  localparam int unsigned BIT_TEL_OVERLOAD = 14;
  localparam int unsigned BIT_AUD_OVERLOAD = 15;

  // ****************************************************************
  // Implemented bit masks (undefined positions read zero)
  // ****************************************************************
  localparam logic [WORD_W-1:0] MASK_PINS = 16'h03ff;
  localparam logic [WORD_W-1:0] MASK_DIRECTION = 16'h83ff;
  localparam logic [WORD_W-1:0] MASK_EVENTS = 16'hfbff;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [WORD_W-1:0] RESET_WORD = 16'h0000;
  localparam logic [PIN_COUNT-1:0] RESET_PINS = 10'h000;

endpackage : gpio_irq_pkg

/* hdl/event_edge_detect.sv */
// Two-stage synchroniser and edge detector for the sixteen event bits.
// Assumes every source comes from a pin or another clock and may change
// at any time relative to sys_clk.
`timescale 1ns/10ps

module event_edge_detect
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [gpio_irq_pkg::WORD_W-1:0] source_async,
  output logic [gpio_irq_pkg::WORD_W-1:0] source_level,
  output logic [gpio_irq_pkg::WORD_W-1:0] source_rise,
  output logic [gpio_irq_pkg::WORD_W-1:0] source_fall
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed
  {
    logic [gpio_irq_pkg::WORD_W-1:0] meta;
    logic [gpio_irq_pkg::WORD_W-1:0] sync;
    logic [gpio_irq_pkg::WORD_W-1:0] last;
  } edge_state_t;

  edge_state_t state_reg;
  edge_state_t state_next;

  // Shift chain; the first stage feeds only the second stage
  always_comb
  begin
    state_next = state_reg;
    state_next.meta = source_async;
    state_next.sync = state_reg.meta;
    state_next.last = state_reg.sync;
  end

  // Synchronous reset clears the chain so no edge is seen while reset is held
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Edges compare the two settled stages only
  assign source_level = state_reg.sync;
  assign source_rise = state_reg.sync & ~state_reg.last;
  assign source_fall = ~state_reg.sync & state_reg.last;

endmodule : event_edge_detect

/* hdl/gpio_edge_interrupt_regs.sv */
// Port data and direction registers and the edge interrupt collector
// for ten general purpose pins and five internal event sources.
// Assumes the serial link framing logic decodes each control word into
// a register index, a one-cycle write strobe and write data on sys_clk,
// and flags the second link word with a level on the same clock.
`timescale 1ns/10ps

module gpio_edge_interrupt_regs
(
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register access from the link framing logic
  input wire logic [gpio_irq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_write,
  input wire logic [gpio_irq_pkg::WORD_W-1:0] reg_wdata,
  output logic [gpio_irq_pkg::WORD_W-1:0] reg_rdata,
  // Second link word marker and serial output control
  input wire logic link_second_word,
  output logic link_serial_out,
  output logic link_serial_out_oe,
  // General purpose pins, split into in, out and enable
  input wire logic [gpio_irq_pkg::PIN_COUNT-1:0] port_pin_in,
  output logic [gpio_irq_pkg::PIN_COUNT-1:0] port_pin_out,
  output logic [gpio_irq_pkg::PIN_COUNT-1:0] port_pin_oe,
  // Internal event sources, asynchronous to sys_clk
  input wire logic conv_ready,
  input wire logic touch_plate_x_plus,
  input wire logic touch_plate_x_minus,
  input wire logic tel_overload,
  input wire logic aud_overload,
  // Combined pending level for the framing logic
  output logic irq_pending_any
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Keep only the implemented bits of a word
  function automatic logic [gpio_irq_pkg::WORD_W-1:0] keep_bits
  (
    input logic [gpio_irq_pkg::WORD_W-1:0] value,
    input logic [gpio_irq_pkg::WORD_W-1:0] mask
  );
    keep_bits = value & mask;
  endfunction : keep_bits

  // Write strobe for one register index
  function automatic logic write_hit
  (
    input logic strobe,
    input logic [gpio_irq_pkg::ADDR_W-1:0] addr,
    input logic [gpio_irq_pkg::ADDR_W-1:0] target
  );
    write_hit = strobe && (addr == target);
  endfunction : write_hit

  // Widen the ten pin bits into a full register word
  function automatic logic [gpio_irq_pkg::WORD_W-1:0] pins_to_word
  (
    input logic [gpio_irq_pkg::PIN_COUNT-1:0] pins
  );
    pins_to_word = {{(gpio_irq_pkg::WORD_W - gpio_irq_pkg::PIN_COUNT){1'b0}},
                    pins};
  endfunction : pins_to_word

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed
  {
    logic [gpio_irq_pkg::WORD_W-1:0] pin_data;
    logic [gpio_irq_pkg::WORD_W-1:0] direction;
    logic [gpio_irq_pkg::WORD_W-1:0] rise_enable;
    logic [gpio_irq_pkg::WORD_W-1:0] fall_enable;
    logic [gpio_irq_pkg::WORD_W-1:0] clear_last;
    logic [gpio_irq_pkg::WORD_W-1:0] pending;
    logic [gpio_irq_pkg::WORD_W-1:0] read_data;
    logic [gpio_irq_pkg::PIN_COUNT-1:0] pin_out;
    logic [gpio_irq_pkg::PIN_COUNT-1:0] pin_oe;
  } regs_state_t;

  regs_state_t state_reg;
  regs_state_t state_next;

  // ****************************************************************
  // Event source gathering
  // ****************************************************************
  logic [gpio_irq_pkg::WORD_W-1:0] source_async;
  logic [gpio_irq_pkg::WORD_W-1:0] source_level;
  logic [gpio_irq_pkg::WORD_W-1:0] source_rise;
  logic [gpio_irq_pkg::WORD_W-1:0] source_fall;
  logic [gpio_irq_pkg::WORD_W-1:0] rise_event;
  logic [gpio_irq_pkg::WORD_W-1:0] fall_event;
  logic [gpio_irq_pkg::WORD_W-1:0] set_event;
  logic [gpio_irq_pkg::WORD_W-1:0] clear_event;
  logic [gpio_irq_pkg::WORD_W-1:0] pin_word;

  // Pack pins and internal sources at their status bit positions;
  // the unused slot stays low so it can never raise an event
  always_comb
  begin
    source_async = '0;
    source_async[gpio_irq_pkg::PIN_COUNT-1:0] = port_pin_in;
    source_async[gpio_irq_pkg::BIT_CONV_READY] = conv_ready;
    source_async[gpio_irq_pkg::BIT_PLATE_XPOS] = touch_plate_x_plus;
    source_async[gpio_irq_pkg::BIT_PLATE_XNEG] = touch_plate_x_minus;
    source_async[gpio_irq_pkg::BIT_TEL_OVERLOAD] = tel_overload;
    source_async[gpio_irq_pkg::BIT_AUD_OVERLOAD] = aud_overload;
  end

  // Pins and sources are asynchronous, so all pass two flip-flops
  event_edge_detect u_edges
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .source_async(source_async),
    .source_level(source_level),
    .source_rise(source_rise),
    .source_fall(source_fall)
  );

  // ****************************************************************
  // Edge qualification
  // ****************************************************************

  // Rising edges: pins, converter, plate X pair, clip pair
  always_comb
  begin
    rise_event = '0;
    rise_event[gpio_irq_pkg::PIN_COUNT-1:0] =
      source_rise[gpio_irq_pkg::PIN_COUNT-1:0] &
      state_reg.rise_enable[gpio_irq_pkg::PIN_COUNT-1:0];
    rise_event[gpio_irq_pkg::BIT_CONV_READY] =
      source_rise[gpio_irq_pkg::BIT_CONV_READY] &
      state_reg.rise_enable[gpio_irq_pkg::BIT_CONV_READY];
    rise_event[gpio_irq_pkg::BIT_PLATE_XPOS] =
      source_rise[gpio_irq_pkg::BIT_PLATE_XPOS] &
      state_reg.rise_enable[gpio_irq_pkg::BIT_PLATE_XPOS];
    rise_event[gpio_irq_pkg::BIT_PLATE_XNEG] =
      source_rise[gpio_irq_pkg::BIT_PLATE_XNEG] &
      state_reg.rise_enable[gpio_irq_pkg::BIT_PLATE_XNEG];
    rise_event[gpio_irq_pkg::BIT_TEL_OVERLOAD] =
      source_rise[gpio_irq_pkg::BIT_TEL_OVERLOAD] &
      state_reg.rise_enable[gpio_irq_pkg::BIT_TEL_OVERLOAD];
    rise_event[gpio_irq_pkg::BIT_AUD_OVERLOAD] =
      source_rise[gpio_irq_pkg::BIT_AUD_OVERLOAD] &
      state_reg.rise_enable[gpio_irq_pkg::BIT_AUD_OVERLOAD];
  end

  // Falling edges: same sources, gated by the falling enables
  always_comb
  begin
    fall_event = '0;
    fall_event[gpio_irq_pkg::PIN_COUNT-1:0] =
      source_fall[gpio_irq_pkg::PIN_COUNT-1:0] &
      state_reg.fall_enable[gpio_irq_pkg::PIN_COUNT-1:0];
    fall_event[gpio_irq_pkg::BIT_CONV_READY] =
      source_fall[gpio_irq_pkg::BIT_CONV_READY] &
      state_reg.fall_enable[gpio_irq_pkg::BIT_CONV_READY];
    fall_event[gpio_irq_pkg::BIT_PLATE_XPOS] =
      source_fall[gpio_irq_pkg::BIT_PLATE_XPOS] &
      state_reg.fall_enable[gpio_irq_pkg::BIT_PLATE_XPOS];
    fall_event[gpio_irq_pkg::BIT_PLATE_XNEG] =
      source_fall[gpio_irq_pkg::BIT_PLATE_XNEG] &
      state_reg.fall_enable[gpio_irq_pkg::BIT_PLATE_XNEG];
    fall_event[gpio_irq_pkg::BIT_TEL_OVERLOAD] =
      source_fall[gpio_irq_pkg::BIT_TEL_OVERLOAD] &
      state_reg.fall_enable[gpio_irq_pkg::BIT_TEL_OVERLOAD];
    fall_event[gpio_irq_pkg::BIT_AUD_OVERLOAD] =
      source_fall[gpio_irq_pkg::BIT_AUD_OVERLOAD] &
      state_reg.fall_enable[gpio_irq_pkg::BIT_AUD_OVERLOAD];
  end

  // Either edge sets the same pending bit
  assign set_event = keep_bits(rise_event | fall_event,
                               gpio_irq_pkg::MASK_EVENTS);

  // ****************************************************************
  // Clear detection
  // ****************************************************************

  // A clear fires only where the written bit goes from zero to one
  // against the previous write; a repeated one does nothing, so the
  // host must write zero before it can clear the same bit again
  always_comb
  begin
    clear_event = '0;
    if (write_hit(reg_write, reg_addr, gpio_irq_pkg::ADDR_IRQ_CLEAR_STATUS))
    begin
      clear_event = keep_bits(reg_wdata & ~state_reg.clear_last,
                              gpio_irq_pkg::MASK_EVENTS);
    end
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // Pin levels as seen after synchronisation
  assign pin_word = pins_to_word(source_level[gpio_irq_pkg::PIN_COUNT-1:0]);

  // Register writes, pending update and read data capture
  always_comb
  begin
    state_next = state_reg;

    // Control writes keep implemented bits only
    if (write_hit(reg_write, reg_addr, gpio_irq_pkg::ADDR_PIN_DATA))
    begin
      state_next.pin_data = keep_bits(reg_wdata,
                                      gpio_irq_pkg::MASK_PINS);
    end
    if (write_hit(reg_write, reg_addr, gpio_irq_pkg::ADDR_DIRECTION))
    begin
      state_next.direction = keep_bits(reg_wdata,
                                       gpio_irq_pkg::MASK_DIRECTION);
    end
    if (write_hit(reg_write, reg_addr, gpio_irq_pkg::ADDR_RISE_ENABLE))
    begin
      state_next.rise_enable = keep_bits(reg_wdata,
                                         gpio_irq_pkg::MASK_EVENTS);
    end
    if (write_hit(reg_write, reg_addr, gpio_irq_pkg::ADDR_FALL_ENABLE))
    begin
      state_next.fall_enable = keep_bits(reg_wdata,
                                         gpio_irq_pkg::MASK_EVENTS);
    end
    if (write_hit(reg_write, reg_addr, gpio_irq_pkg::ADDR_IRQ_CLEAR_STATUS))
    begin
      state_next.clear_last = keep_bits(reg_wdata,
                                        gpio_irq_pkg::MASK_EVENTS);
    end

    // Sticky pending; a set in the clearing cycle wins so no edge is
    // lost while software acknowledges an earlier one
    state_next.pending = (state_reg.pending &
                          ~clear_event) |
                         set_event;

    // Pins load the new data and direction on the same edge as the registers
    state_next.pin_out =
      state_next.pin_data[gpio_irq_pkg::PIN_COUNT-1:0];
    state_next.pin_oe =
      state_next.direction[gpio_irq_pkg::PIN_COUNT-1:0];

    // Read data is sampled every cycle from the presented index
    unique case (reg_addr)
      gpio_irq_pkg::ADDR_PIN_DATA:
      begin
        state_next.read_data = pin_word;
      end
      gpio_irq_pkg::ADDR_DIRECTION:
      begin
        state_next.read_data = state_reg.direction;
      end
      gpio_irq_pkg::ADDR_RISE_ENABLE:
      begin
        state_next.read_data = state_reg.rise_enable;
      end
      gpio_irq_pkg::ADDR_FALL_ENABLE:
      begin
        state_next.read_data = state_reg.fall_enable;
      end
      gpio_irq_pkg::ADDR_IRQ_CLEAR_STATUS:
      begin
        // Pins in 0-9, converter at 11, plate and clip bits above
        state_next.read_data = keep_bits(
          state_reg.pending,
          gpio_irq_pkg::MASK_EVENTS);
      end
      default:
      begin
        // Indices outside this block read as zero here
        state_next.read_data = gpio_irq_pkg::RESET_WORD;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Synchronous active-low reset: pins come up as inputs, all off
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_reg.pin_data <= gpio_irq_pkg::RESET_WORD;
      state_reg.direction <= gpio_irq_pkg::RESET_WORD;
      state_reg.rise_enable <= gpio_irq_pkg::RESET_WORD;
      state_reg.fall_enable <= gpio_irq_pkg::RESET_WORD;
      state_reg.clear_last <= gpio_irq_pkg::RESET_WORD;
      state_reg.pending <= gpio_irq_pkg::RESET_WORD;
      state_reg.read_data <= gpio_irq_pkg::RESET_WORD;
      state_reg.pin_out <= gpio_irq_pkg::RESET_PINS;
      state_reg.pin_oe <= gpio_irq_pkg::RESET_PINS;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Pin drivers come straight from flip-flops
  assign port_pin_out = state_reg.pin_out;
  assign port_pin_oe = state_reg.pin_oe;
  assign reg_rdata = state_reg.read_data;

  // During the second word this block owns the serial output: either
  // a solid low or released; outside it the framing logic drives
  assign link_serial_out = 1'b0;
  assign link_serial_out_oe = link_second_word &
    state_reg.direction[gpio_irq_pkg::BIT_DRIVE_LOW];

  // Any pending source, for the framing logic's interrupt pin
  assign irq_pending_any = |state_reg.pending;

endmodule : gpio_edge_interrupt_regs

/* tb/gpio_edge_interrupt_regs_assertions.sv */
// Concurrent checks on the port and edge interrupt register block.
// Sees only the top ports; bound from the testbench top file.
`timescale 1ns/10ps

module gpio_edge_interrupt_regs_checker
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [gpio_irq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_write,
  input wire logic [gpio_irq_pkg::WORD_W-1:0] reg_wdata,
  input wire logic [gpio_irq_pkg::WORD_W-1:0] reg_rdata,
  input wire logic link_second_word,
  input wire logic link_serial_out,
  input wire logic link_serial_out_oe,
  input wire logic [gpio_irq_pkg::PIN_COUNT-1:0] port_pin_in,
  input wire logic [gpio_irq_pkg::PIN_COUNT-1:0] port_pin_out,
  input wire logic [gpio_irq_pkg::PIN_COUNT-1:0] port_pin_oe,
  input wire logic conv_ready,
  input wire logic touch_plate_x_plus,
  input wire logic touch_plate_x_minus,
  input wire logic tel_overload,
  input wire logic aud_overload,
  input wire logic irq_pending_any
);
  // ****************************************************
  // Shadow state
  // ****************************************************
  logic drive_low_reg;
  logic ever_en_reg;
  logic [2:0] quiet_reg;
  logic [14:0] src_last_reg;
  logic [15:0] clr_last_reg;
  logic [14:0] src_now;
  assign src_now = {conv_ready, touch_plate_x_plus, touch_plate_x_minus,
    tel_overload, aud_overload, port_pin_in};
  // Quiet counts unchanged source cycles, so no edge is still in flight
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      drive_low_reg <= 1'b0;
      ever_en_reg <= 1'b0;
      quiet_reg <= 3'h0;
      clr_last_reg <= 16'h0000;
    end
    else
    begin
      if (reg_write && reg_addr == 4'h1)
        drive_low_reg <= reg_wdata[15];
      if (reg_write && reg_addr == 4'h4)
        clr_last_reg <= reg_wdata;
      if (reg_write && (reg_addr == 4'h2 || reg_addr == 4'h3)
          && (reg_wdata & 16'hfbff) != 16'h0000)
        ever_en_reg <= 1'b1;
      if (src_now != src_last_reg)
        quiet_reg <= 3'h0;
      else if (quiet_reg != 3'h7)
        quiet_reg <= quiet_reg + 3'h1;
    end
    src_last_reg <= src_now;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ****************************************************
  // Properties
  // ****************************************************
  AST_PIN_OUT:
    assert property (reg_write && reg_addr == 4'h0
      |=> port_pin_out == $past(reg_wdata[9:0]))
    else $error("Pin output differs from written data");
  AST_PIN_DIR:
    assert property (reg_write && reg_addr == 4'h1
      |=> port_pin_oe == $past(reg_wdata[9:0]))
    else $error("Pin enable differs from direction");
  // Read data lags the pin by two sync stages plus the read register
  AST_PIN_READ:
    assert property (reg_addr == 4'h0 && quiet_reg == 3'h7
      |=> reg_rdata == {6'h00, $past(port_pin_in, 3)})
    else $error("Data read differs from pin level");
  AST_LINK_OE:
    assert property (link_serial_out_oe ==
      (link_second_word && drive_low_reg))
    else $error("Serial output enable wrong");
  AST_LINK_LOW:
    assert property (link_serial_out_oe |-> !link_serial_out)
    else $error("Serial output driven high");
  AST_UNMAPPED:
    assert property (reg_addr > 4'h4 |=> reg_rdata == 16'h0000)
    else $error("Unmapped read not zero");
  AST_BIT_TEN:
    assert property (reg_addr inside {[4'h1:4'h4]} |=> !reg_rdata[10])
    else $error("Reserved bit ten reads one");
  AST_STATUS:
    assert property (reg_addr == 4'h4
      |=> (|reg_rdata) == $past(irq_pending_any))
    else $error("Status read disagrees with pending flag");
  AST_STICKY:
    assert property (irq_pending_any && !(reg_write && reg_addr == 4'h4)
      |=> irq_pending_any)
    else $error("Pending dropped without a clear");
  AST_NO_ENABLE:
    assert property (!ever_en_reg |-> !irq_pending_any)
    else $error("Pending without any edge enable");
  AST_CLEAR:
    assert property (reg_write && reg_addr == 4'h4 && quiet_reg == 3'h7
      && reg_wdata == 16'hffff && (clr_last_reg & 16'hfbff) == 16'h0000
      |=> !irq_pending_any)
    else $error("Full clear left a pending bit");
endmodule : gpio_edge_interrupt_regs_checker

/* tb/host_link_model.sv */
// Host controller model issuing decoded register accesses.
// Assumes the block takes a one-cycle write strobe, read latency one.
`timescale 1ns/10ps

module host_link_model
(
  input wire logic sys_clk,
  output logic [gpio_irq_pkg::ADDR_W-1:0] reg_addr,
  output logic reg_write,
  output logic [gpio_irq_pkg::WORD_W-1:0] reg_wdata,
  input wire logic [gpio_irq_pkg::WORD_W-1:0] reg_rdata
);
  // Idle bus from time zero
  initial
  begin
    reg_addr = 4'h0;
    reg_write = 1'b0;
    reg_wdata = 16'h0000;
  end
  // One strobe; data shows the inverse once released, never stale
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_write <= 1'b1;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  // Address sampled at the next edge, data settled just after it
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    @(posedge sys_clk);
    #1;
    d = reg_rdata;
  endtask : rd
  // Clears act on a rising written bit, so a zero always goes first
  task automatic clr(input logic [15:0] m);
    wr(4'h4, 16'h0000);
    wr(4'h4, m);
  endtask : clr
endmodule : host_link_model

/* tb/tb_gpio_edge_interrupt_regs.sv */
// Self-checking bench for the port and edge interrupt registers.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/10ps

module tb_gpio_edge_interrupt_regs;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } row_t;
  logic sys_clk;
  logic reset_n;
  logic link_second_word;
  logic [15:0] src;
  logic [3:0] reg_addr;
  logic reg_write;
  logic [15:0] reg_wdata, reg_rdata, rv, m;
  logic link_serial_out, link_serial_out_oe, irq_pending_any;
  logic [9:0] port_pin_in, port_pin_out, port_pin_oe;
  int err_count, compares, cycles;
  row_t rows [8];
  // Pin wire: the block wins where enabled, else the outside level
  assign port_pin_in = (port_pin_oe & port_pin_out) |
    (~port_pin_oe & src[9:0]);
  host_link_model host_u (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  gpio_edge_interrupt_regs dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .link_second_word(link_second_word),
    .link_serial_out(link_serial_out),
    .link_serial_out_oe(link_serial_out_oe), .port_pin_in(port_pin_in),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
    .conv_ready(src[11]), .touch_plate_x_plus(src[12]),
    .touch_plate_x_minus(src[13]), .tel_overload(src[14]),
    .aud_overload(src[15]), .irq_pending_any(irq_pending_any));
  // ****************************************************
  // Clock, timeout and checks
  // ****************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Whole run needs about 900 cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      err_count++;
      conclude();
    end
  end
  task automatic chk16(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk16
  task automatic chk1(string n, logic e, logic g);
    chk16(n, {15'h0000, e}, {15'h0000, g});
  endtask : chk1
  // Status word and summary flag after a settled source change
  task automatic chk_st(logic [15:0] e);
    host_u.rd(4'h4, rv);
    chk16("status", e, rv);
    chk1("pending_any", |e, irq_pending_any);
  endtask : chk_st
  task automatic pulse(int b, logic v);
    @(posedge sys_clk);
    src[b] <= v;
    repeat (5) @(posedge sys_clk);
  endtask : pulse
  task automatic conclude();
    $display("Compares %0d, errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  // ****************************************************
  // Main sequence
  // ****************************************************
  initial
  begin
    reset_n = 1'b0;
    link_second_word = 1'b0;
    src = 16'h0000;
    rows = '{'{4'h1, 16'hffff, 16'h83ff}, '{4'h0, 16'h02a5, 16'h02a5},
      '{4'h0, 16'hfc5a, 16'h005a}, '{4'h2, 16'hffff, 16'hfbff},
      '{4'h3, 16'hffff, 16'hfbff}, '{4'h7, 16'hffff, 16'h0000},
      '{4'hf, 16'h1234, 16'h0000}, '{4'h1, 16'h0000, 16'h0000}};
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 5; a++)
    begin
      host_u.rd(a[3:0], rv);
      chk16("reset value", 16'h0000, rv);
    end
    // Plain write then read back, pins looping through the outputs
    foreach (rows[i])
    begin
      host_u.wr(rows[i].addr, rows[i].wdata);
      repeat (4) @(posedge sys_clk);
      host_u.rd(rows[i].addr, rv);
      chk16("readback", rows[i].exp, rv);
    end
    // Drive-low bit only acts inside the second word
    host_u.wr(4'h1, 16'h8000);
    @(posedge sys_clk) link_second_word <= 1'b1;
    @(posedge sys_clk) #1;
    chk1("link_oe", 1'b1, link_serial_out_oe);
    chk1("link_out", 1'b0, link_serial_out);
    host_u.wr(4'h1, 16'h0000);
    #1;
    chk1("link_oe", 1'b0, link_serial_out_oe);
    @(posedge sys_clk) link_second_word <= 1'b0;
    // Every source, each edge with its own enable alone
    for (int b = 0; b < 16; b++)
    begin
      if (b == 10)
        continue;
      m = 16'h0001 << b;
      host_u.wr(4'h2, m);
      host_u.wr(4'h3, 16'h0000);
      host_u.clr(16'hffff);
      pulse(b, 1'b1);
      chk_st(m);
      host_u.clr(m);
      chk_st(16'h0000);
      pulse(b, 1'b0);
      chk_st(16'h0000);
      host_u.wr(4'h2, 16'h0000);
      host_u.wr(4'h3, m);
      pulse(b, 1'b1);
      chk_st(16'h0000);
      pulse(b, 1'b0);
      chk_st(m);
      host_u.wr(4'h4, m);
      chk_st(m);
    end
    // Reset in mid-run returns the direction and pin enables to their idle values
    host_u.wr(4'h1, 16'h83ff);
    reset_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    host_u.rd(4'h1, rv);
    chk16("direction", 16'h0000, rv);
    chk16("pin_oe", 16'h0000, {6'h00, port_pin_oe});
    conclude();
  end
endmodule : tb_gpio_edge_interrupt_regs

bind gpio_edge_interrupt_regs gpio_edge_interrupt_regs_checker chk_u (
  .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .link_second_word(link_second_word), .link_serial_out(link_serial_out),
  .link_serial_out_oe(link_serial_out_oe), .port_pin_in(port_pin_in),
  .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
  .conv_ready(conv_ready), .touch_plate_x_plus(touch_plate_x_plus),
  .touch_plate_x_minus(touch_plate_x_minus), .tel_overload(tel_overload),
  .aud_overload(aud_overload), .irq_pending_any(irq_pending_any));
